// ==== rtl/isme_top.sv ====
// Function
// - Sole bus master; no arbitration logic, any number of slaves.
// - All bit timing derives from the host clock.
// - Host clock first passes a fixed divide-by-sixteen prescaler.
// - Bit rate is clock over four times (16 times ratio plus 4).
// - Slave may hold the clock low; engine waits until released.
// - Start pulls data low while clock stays high.
// - Start only at the beginning of a transaction, never after a byte.
// - Stop releases data high while clock stays high.
// - Stop may be issued at any point of a transaction.
// - Data changes only while clock is low.
// - Write sends start, 2 or 3 acked bytes, stop.
// - Data shifts left out of a 24-bit register, MSB first.
// - Bit 0 of the first byte selects write (0) or read (1).
// - A control bit picks two or three bytes for a write.
// - Read sends one acked byte, receives one, answers NACK, stops.
// - Received byte shifts into the third byte field.
// - Completion raises an interrupt toward the host.
// - Status flag reports whether every expected acknowledge came.
// - Software can disable the engine and drive both pins directly.
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "isme_regs.svh"
module isme_top
    import isme_pkg::*;
#(
    parameter int DIV_W = 8
) (
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    output logic             xfer_done
);
    if (DIV_W < 1 || DIV_W > 8) begin : g_bad_width
        $error("DIV_W must lie between 1 and 8");
    end

    // ==========================================================
    // Declarations
    isme_tick_if #(.DIV_W(DIV_W)) tk ();

    logic [DIV_W-1:0] bit_rate_divide_ratio_ff;
    logic             write_three_byte_select_ff;
    logic             en_ff;
    logic             sw_scl_low_ff;
    logic             sw_sda_low_ff;
    logic [23:0]      data_ff;
    isme_state_t      state_ff;
    logic [1:0]       ph_ff;
    logic [3:0]       bit_ff;
    logic [1:0]       byte_ff;
    logic             rd_ff;
    logic             w3_ff;
    logic             abort_ff;
    logic             scl_oe_ff;
    logic             sda_oe_ff;
    logic             all_acks_received_flag_ff;
    logic             done_ff;
    logic             xfer_done_ff;
    logic [31:0]      rdata_ff;
    logic [31:0]      nxt_rdata;
    logic             wr_ctrl;
    logic             wr_data;
    logic             wr_cmd;
    logic             wr_stat;
    logic             busy;
    logic             start_go;
    logic             q;
    logic             rx_byte;
    logic             last_byte;
    logic             drive_bit_low;
    logic             samp;
    logic             fin;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    // ==========================================================
    // Decode and sequencing terms
    assign wr_ctrl  = reg_wr && hit(reg_addr, `ISME_CTRL_OFS);
    assign wr_data  = reg_wr && hit(reg_addr, `ISME_DATA_OFS);
    assign wr_cmd   = reg_wr && hit(reg_addr, `ISME_CMD_OFS);
    assign wr_stat  = reg_wr && hit(reg_addr, `ISME_STAT_OFS);
    assign busy     = (state_ff != ISME_IDLE);
    // No arbitration: a start is taken only while idle
    assign start_go = wr_cmd && reg_wdata[`ISME_CMD_START_BIT] && en_ff && !busy;
    assign q        = tk.qtr_en;
    assign rx_byte  = rd_ff && (byte_ff == 2'h1);
    assign last_byte = (byte_ff == 2'h2) ||
                       ((byte_ff == 2'h1) && !(w3_ff && !rd_ff));
    // Ack slot of a received byte is released: master NACK
    assign drive_bit_low = (bit_ff != `ISME_ACK_SLOT) && !rx_byte && !data_ff[23];
    assign samp = en_ff && q && !abort_ff && (state_ff == ISME_BITS) && (ph_ff == 2'h2);
    assign fin  = en_ff && q && (state_ff == ISME_STOP) && (ph_ff == 2'h3);

    // ==========================================================
    // Quarter-bit timebase
    assign tk.run  = en_ff && busy;
    assign tk.hold = !scl_oe_ff && !scl_i;
    assign tk.div  = bit_rate_divide_ratio_ff;

    isme_qtr_div #(.DIV_W(DIV_W)) u_div (
        .ref_clk (ref_clk),
        .reset   (reset),
        .tk      (tk)
    );

    // ==========================================================
    // Control register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            bit_rate_divide_ratio_ff   <= DIV_W'(`ISME_DIV_RST);
            write_three_byte_select_ff <= 1'b0;
            en_ff                      <= `ISME_EN_RST;
            sw_scl_low_ff              <= 1'b0;
            sw_sda_low_ff              <= 1'b0;
        end else if (wr_ctrl) begin
            bit_rate_divide_ratio_ff   <= reg_wdata[`ISME_CTRL_DIV_LSB +: DIV_W];
            write_three_byte_select_ff <= reg_wdata[`ISME_CTRL_W3_BIT];
            en_ff                      <= reg_wdata[`ISME_CTRL_EN_BIT];
            sw_scl_low_ff              <= reg_wdata[`ISME_CTRL_SWSCL_BIT];
            sw_sda_low_ff              <= reg_wdata[`ISME_CTRL_SWSDA_BIT];
        end
    end

    // ==========================================================
    // Data register: shifts out MSB first, receives into low byte
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            data_ff <= 24'h000000;
        end else if (samp && (bit_ff != `ISME_ACK_SLOT)) begin
            if (rx_byte) begin
                data_ff[7:0] <= {data_ff[6:0], sda_i};
            end else begin
                data_ff <= {data_ff[22:0], 1'b0};
            end
        end else if (wr_data && !busy) begin
            data_ff <= reg_wdata[23:0];
        end
    end

    // ==========================================================
    // Stop request: set wins over the clear
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            abort_ff <= 1'b0;
        end else if (wr_cmd && reg_wdata[`ISME_CMD_STOP_BIT] && busy) begin
            abort_ff <= 1'b1;
        end else if (state_ff != ISME_START && state_ff != ISME_BITS) begin
            abort_ff <= 1'b0;
        end
    end

    // ==========================================================
    // Transaction sequencer and open-drain pin drive
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_ff  <= ISME_IDLE;
            ph_ff     <= 2'h0;
            bit_ff    <= 4'h0;
            byte_ff   <= 2'h0;
            rd_ff     <= 1'b0;
            w3_ff     <= 1'b0;
            scl_oe_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
        end else if (!en_ff) begin
            state_ff  <= ISME_IDLE;
            ph_ff     <= 2'h0;
            scl_oe_ff <= sw_scl_low_ff;
            sda_oe_ff <= sw_sda_low_ff;
        end else if (start_go) begin
            state_ff  <= ISME_START;
            ph_ff     <= 2'h0;
            bit_ff    <= 4'h0;
            byte_ff   <= 2'h0;
            rd_ff     <= data_ff[`ISME_DIR_BIT];
            w3_ff     <= write_three_byte_select_ff;
            scl_oe_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
        end else if (!busy) begin
            scl_oe_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
        end else if (q) begin
            if (abort_ff && (state_ff == ISME_START || state_ff == ISME_BITS)) begin
                // Clock goes low first so the data edge that follows is safe
                state_ff  <= ISME_STOP;
                ph_ff     <= 2'h0;
                scl_oe_ff <= 1'b1;
            end else begin
                unique case (state_ff)
                    ISME_IDLE: begin
                        ph_ff <= 2'h0;
                    end
                    ISME_START: begin
                        unique case (ph_ff)
                            2'h0: begin
                                ph_ff <= 2'h1;
                            end
                            2'h1: begin
                                sda_oe_ff <= 1'b1;
                                ph_ff     <= 2'h2;
                            end
                            2'h2: begin
                                scl_oe_ff <= 1'b1;
                                ph_ff     <= 2'h3;
                            end
                            2'h3: begin
                                state_ff <= ISME_BITS;
                                ph_ff    <= 2'h0;
                            end
                        endcase
                    end
                    ISME_BITS: begin
                        unique case (ph_ff)
                            2'h0: begin
                                sda_oe_ff <= drive_bit_low;
                                ph_ff     <= 2'h1;
                            end
                            2'h1: begin
                                scl_oe_ff <= 1'b0;
                                ph_ff     <= 2'h2;
                            end
                            2'h2: begin
                                ph_ff <= 2'h3;
                            end
                            2'h3: begin
                                scl_oe_ff <= 1'b1;
                                ph_ff     <= 2'h0;
                                if (bit_ff == `ISME_ACK_SLOT) begin
                                    bit_ff <= 4'h0;
                                    if (last_byte) begin
                                        state_ff <= ISME_STOP;
                                    end else begin
                                        byte_ff <= byte_ff + 2'h1;
                                    end
                                end else begin
                                    bit_ff <= bit_ff + 4'h1;
                                end
                            end
                        endcase
                    end
                    ISME_STOP: begin
                        unique case (ph_ff)
                            2'h0: begin
                                sda_oe_ff <= 1'b1;
                                ph_ff     <= 2'h1;
                            end
                            2'h1: begin
                                scl_oe_ff <= 1'b0;
                                ph_ff     <= 2'h2;
                            end
                            2'h2: begin
                                sda_oe_ff <= 1'b0;
                                ph_ff     <= 2'h3;
                            end
                            2'h3: begin
                                state_ff <= ISME_IDLE;
                                ph_ff    <= 2'h0;
                            end
                        endcase
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Completion status
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            all_acks_received_flag_ff <= 1'b0;
        end else if (start_go) begin
            all_acks_received_flag_ff <= 1'b1;
        end else if (samp && (bit_ff == `ISME_ACK_SLOT) && !rx_byte && sda_i) begin
            all_acks_received_flag_ff <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            done_ff      <= 1'b0;
            xfer_done_ff <= 1'b0;
        end else begin
            xfer_done_ff <= fin;
            if (fin) begin
                done_ff <= 1'b1;
            end else if (wr_stat && reg_wdata[`ISME_STAT_DONE_BIT]) begin
                done_ff <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Read path: data stands one cycle after the strobe
    always_comb begin
        nxt_rdata = 32'h00000000;
        case (reg_addr)
            `ISME_CTRL_OFS: begin
                nxt_rdata[7:0] = 8'(bit_rate_divide_ratio_ff);
                nxt_rdata[`ISME_CTRL_W3_BIT]    = write_three_byte_select_ff;
                nxt_rdata[`ISME_CTRL_EN_BIT]    = en_ff;
                nxt_rdata[`ISME_CTRL_SWSCL_BIT] = sw_scl_low_ff;
                nxt_rdata[`ISME_CTRL_SWSDA_BIT] = sw_sda_low_ff;
            end
            `ISME_DATA_OFS: begin
                nxt_rdata[23:0] = data_ff;
            end
            `ISME_CMD_OFS: begin
                nxt_rdata[`ISME_CMD_STOP_BIT] = abort_ff;
            end
            `ISME_STAT_OFS: begin
                nxt_rdata[`ISME_STAT_BUSY_BIT] = busy;
                nxt_rdata[`ISME_STAT_DONE_BIT] = done_ff;
                nxt_rdata[`ISME_STAT_ACK_BIT]  = all_acks_received_flag_ff;
                nxt_rdata[`ISME_STAT_SCL_BIT]  = scl_i;
                nxt_rdata[`ISME_STAT_SDA_BIT]  = sda_i;
                nxt_rdata[9:8]                 = byte_ff;
                nxt_rdata[15:12]               = bit_ff;
            end
            default: begin
                nxt_rdata = 32'h00000000;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rdata_ff <= 32'h00000000;
        end else if (reg_rd) begin
            rdata_ff <= nxt_rdata;
        end else begin
            rdata_ff <= 32'h00000000;
        end
    end

    // ==========================================================
    // Outputs: lines are only pulled low or released
    assign reg_rdata = rdata_ff;
    assign scl_o     = 1'b0;
    assign sda_o     = 1'b0;
    assign scl_oe    = scl_oe_ff;
    assign sda_oe    = sda_oe_ff;
    assign xfer_done = xfer_done_ff;

    // ==========================================================
    // Checks
    a_stretch_hold: assert property (
        @(posedge ref_clk) disable iff (reset)
        (tk.run && tk.hold) |=> ($stable(ph_ff) && $stable(state_ff))
    ) else $error("sequencer advanced while clock held low");

    a_start_edge: assert property (
        @(posedge ref_clk) disable iff (reset)
        (state_ff == ISME_START && $rose(sda_oe_ff)) |-> !scl_oe_ff
    ) else $error("start data edge with clock low");

    a_single_start: assert property (
        @(posedge ref_clk) disable iff (reset)
        (state_ff == ISME_START && $past(state_ff) != ISME_START)
            |-> $past(state_ff) == ISME_IDLE
    ) else $error("start entered mid transaction");

    a_stop_edge: assert property (
        @(posedge ref_clk) disable iff (reset)
        (state_ff == ISME_STOP && $fell(sda_oe_ff)) |-> !scl_oe_ff
    ) else $error("stop data edge with clock low");

    a_data_stable: assert property (
        @(posedge ref_clk) disable iff (reset)
        (en_ff && state_ff == ISME_BITS && $changed(sda_oe_ff)) |-> $past(scl_oe_ff)
    ) else $error("data moved while clock released");

    a_byte_count: assert property (
        @(posedge ref_clk) disable iff (reset)
        ($past(state_ff) == ISME_BITS && state_ff == ISME_STOP && !$past(abort_ff))
            |-> $past(byte_ff) == (($past(rd_ff) || !$past(w3_ff)) ? 2'h1 : 2'h2)
    ) else $error("wrong number of bytes before stop");

    a_done_pulse: assert property (
        @(posedge ref_clk) disable iff (reset)
        xfer_done_ff |-> (state_ff == ISME_IDLE && done_ff) ##1 !xfer_done_ff
    ) else $error("completion pulse out of step");

    a_ack_miss: assert property (
        @(posedge ref_clk) disable iff (reset)
        (samp && bit_ff == `ISME_ACK_SLOT && !rx_byte && sda_i) |=> !all_acks_received_flag_ff
    ) else $error("missing acknowledge not reported");

    a_bitbang_pins: assert property (
        @(posedge ref_clk) disable iff (reset)
        !en_ff |=> (scl_oe_ff == $past(sw_scl_low_ff) && sda_oe_ff == $past(sw_sda_low_ff))
    ) else $error("pins not under software control");
endmodule : isme_top
`default_nettype wire

// ==== pkg/isme_regs.svh ====
`ifndef ISME_REGS_SVH
`define ISME_REGS_SVH

// ==========================================================
// Register offsets
`define ISME_CTRL_OFS       8'h00
`define ISME_DATA_OFS       8'h04
`define ISME_CMD_OFS        8'h08
`define ISME_STAT_OFS       8'h0C

// ==========================================================
// Control fields
`define ISME_CTRL_DIV_LSB   0
`define ISME_CTRL_W3_BIT    8
`define ISME_CTRL_EN_BIT    9
`define ISME_CTRL_SWSCL_BIT 10
`define ISME_CTRL_SWSDA_BIT 11
`define ISME_DIV_RST        8'h1F
`define ISME_EN_RST         1'b1

// ==========================================================
// Command and status fields
`define ISME_CMD_START_BIT  0
`define ISME_CMD_STOP_BIT   1
`define ISME_STAT_BUSY_BIT  0
`define ISME_STAT_DONE_BIT  1
`define ISME_STAT_ACK_BIT   2
`define ISME_STAT_SCL_BIT   3
`define ISME_STAT_SDA_BIT   4

// ==========================================================
// Data layout and timing counts
`define ISME_DIR_BIT        16
`define ISME_ACK_SLOT       4'h8
`define ISME_PRESCALE       16
`define ISME_QTR_TAIL       4

`endif

// ==== pkg/isme_pkg.sv ====
`default_nettype none
package isme_pkg;
    typedef enum logic [1:0] {
        ISME_IDLE  = 2'b00,
        ISME_START = 2'b01,
        ISME_BITS  = 2'b10,
        ISME_STOP  = 2'b11
    } isme_state_t;
endpackage : isme_pkg
`default_nettype wire

// ==== pkg/isme_tick_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface isme_tick_if #(
    parameter int DIV_W = 8
);
    logic             run;
    logic             hold;
    logic [DIV_W-1:0] div;
    logic             qtr_en;

    modport eng (output run, output hold, output div, input qtr_en);
    modport gen (input run, input hold, input div, output qtr_en);
endinterface : isme_tick_if
`default_nettype wire

// ==== rtl/isme_qtr_div.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "isme_regs.svh"
module isme_qtr_div #(
    parameter int DIV_W = 8
) (
    input  wire logic ref_clk,
    input  wire logic reset,
    isme_tick_if.gen  tk
);
    localparam logic [3:0] PRE_LAST  = 4'(`ISME_PRESCALE - 1);
    localparam logic [1:0] TAIL_LAST = 2'(`ISME_QTR_TAIL - 1);

    logic [3:0]       pre_ff;
    logic [DIV_W-1:0] dcnt_ff;
    logic [1:0]       tail_ff;
    logic             at_ratio;

    assign at_ratio  = (dcnt_ff >= tk.div);
    assign tk.qtr_en = tk.run && !tk.hold && at_ratio && (tail_ff == TAIL_LAST);

    // ==========================================================
    // Fixed divide by 16, then ratio count, then four-cycle tail
    always_ff @(posedge ref_clk) begin
        if (reset || !tk.run || tk.hold || tk.qtr_en) begin
            pre_ff  <= 4'h0;
            dcnt_ff <= '0;
            tail_ff <= 2'h0;
        end else if (!at_ratio) begin
            pre_ff <= pre_ff + 4'h1;
            if (pre_ff == PRE_LAST) begin
                dcnt_ff <= dcnt_ff + DIV_W'(1);
            end
        end else begin
            tail_ff <= tail_ff + 2'h1;
        end
    end

    a_quarter_gap: assert property (
        @(posedge ref_clk) disable iff (reset)
        tk.qtr_en |=> !tk.qtr_en [*3]
    ) else $error("quarter ticks closer than four cycles");
endmodule : isme_qtr_div
`default_nettype wire

// ==== testbench/isme_slave_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module isme_slave_model (
    input  wire logic       ref_clk,
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic       nack,
    input  wire logic       stretch,
    input  wire logic [7:0] rd_byte,
    output logic            scl_pull,
    output logic            sda_pull
);
    logic scl_p, sda_p, rd;
    int   k, b, nk, nb, hold;
    initial begin
        b = -2;
        hold = 0;
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end
    // ==========
    // Bit and byte tracking
    always @(posedge ref_clk) begin
        scl_p <= scl;
        sda_p <= sda;
        hold <= (hold > 0) ? hold - 1 : 0;
        scl_pull <= hold > 1;
        if (scl_p && scl && sda_p !== sda) begin
            k <= 8;
            b <= sda ? -2 : -1;
            rd <= 1'b0;
            sda_pull <= 1'b0;
        end else if (scl_p && !scl && b > -2) begin
            nk = (k == 8) ? 0 : k + 1;
            nb = (k == 8) ? b + 1 : b;
            k <= nk;
            b <= nb;
            hold <= stretch ? 30 : 0;
            sda_pull <= (nk == 8) ? !nack && !(rd && nb > 0)
                                  : rd && nb == 1 && !rd_byte[7 - nk];
        end
        if (!scl_p && scl && b == 0 && k == 7) rd <= sda;
    end
endmodule // isme_slave_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "isme_regs.svh"
module tb_top;
    logic        ref_clk, reset, reg_wr, reg_rd, xfer_done;
    logic        scl_o, scl_oe, sda_o, sda_oe, s_scl, s_sda, nack, stretch;
    logic [7:0]  reg_addr, rb;
    logic [31:0] reg_wdata, reg_rdata, rv, bits;
    int          fail_count, n_checks, nbits, n_st, n_sp, cyc, t_rise, per;
    wire scl_w = (scl_oe ? scl_o : 1'b1) & !s_scl;
    wire sda_w = (sda_oe ? sda_o : 1'b1) & !s_sda;
    logic scl_p, sda_p;

    isme_top u_dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe(sda_oe), .xfer_done(xfer_done));
    isme_slave_model u_slave (.ref_clk(ref_clk), .scl(scl_w), .sda(sda_w), .nack(nack),
        .stretch(stretch), .rd_byte(rb), .scl_pull(s_scl), .sda_pull(s_sda));

    // ==========
    // Wire monitor
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        scl_p <= scl_w;
        sda_p <= sda_w;
        if (scl_p && scl_w && sda_p && !sda_w) begin
            n_st <= n_st + 1;
            nbits <= 0;
        end
        if (scl_p && scl_w && !sda_p && sda_w) n_sp <= n_sp + 1;
        if (!scl_p && scl_w) begin
            bits <= {bits[30:0], sda_w};
            nbits <= nbits + 1;
            per <= cyc - t_rise;
            t_rise <= cyc;
        end
    end

    // ==========
    // Tasks
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        rv = reg_rdata;
    endtask
    task automatic wdone();
        int i;
        for (i = 0; i < 20000 && xfer_done !== 1'b1; i++) @(posedge ref_clk);
        if (i == 20000) begin
            fail_count++;
            conclude();
        end
    endtask
    // Wire bits incl. ack slots and the stop's clock rise
    function automatic logic [31:0] exp_bits(input logic [23:0] d, input logic w3);
        if (d[16]) return 32'({d[23:16], 1'b0, rb, 2'b10});
        if (w3) return 32'({d[23:16], 1'b0, d[15:8], 1'b0, d[7:0], 2'b00});
        return 32'({d[23:16], 1'b0, d[15:8], 2'b00});
    endfunction
    task automatic run(input logic [31:0] ctl, input logic [23:0] d, input logic ack);
        int n;
        n = (d[16] || !ctl[8]) ? 19 : 28;
        wr(`ISME_STAT_OFS, 32'h2);
        wr(`ISME_CTRL_OFS, ctl);
        wr(`ISME_DATA_OFS, {8'h00, d});
        n_st = 0;
        n_sp = 0;
        wr(`ISME_CMD_OFS, 32'h1);
        wdone();
        if (ack) begin
            chk(32'(nbits), 32'(n));
            chk(bits & ((32'h1 << n) - 1), exp_bits(d, ctl[8]));
        end
        chk(32'(n_st * 2 + n_sp), 32'h3);
        rd(`ISME_STAT_OFS);
        chk(rv & 32'h7, {29'h0, ack, 2'b10});
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    initial begin
        reset = 1'b1;
        {reg_wr, reg_rd, nack, stretch} = 4'h0;
        {reg_addr, rb, reg_wdata, bits} = '0;
        {fail_count, n_checks, nbits, n_st, n_sp, cyc, t_rise, per} = '0;
        void'($urandom(32'h13E1));
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        rd(`ISME_CTRL_OFS);
        chk(rv, 32'h0000021F);
        rd(8'h10);
        chk(rv, 32'h0);
        rd(`ISME_STAT_OFS);
        chk(rv & 32'h19, 32'h18);
        for (int i = 0; i < 4; i++) begin
            run({22'h0, 1'b1, i[0], 8'(i / 2)}, 24'($urandom) & 24'hFEFFFF, 1'b1);
            chk(32'(per), 32'(4 * (16 * (i / 2) + 4)));
        end
        stretch <= 1'b1;
        run(32'h300, 24'($urandom) & 24'hFEFFFF, 1'b1);
        stretch <= 1'b0;
        nack <= 1'b1;
        run(32'h200, 24'hA05A3C, 1'b0);
        nack <= 1'b0;
        rb = 8'($urandom);
        run(32'h300, 24'($urandom) | 24'h010000, 1'b1);
        rd(`ISME_DATA_OFS);
        chk({24'h0, rv[7:0]}, {24'h0, rb});
        // Abort in mid-byte
        wr(`ISME_DATA_OFS, 32'h00A412);
        n_sp = 0;
        wr(`ISME_CMD_OFS, 32'h1);
        repeat (60) @(posedge ref_clk);
        wr(`ISME_CMD_OFS, 32'h2);
        wdone();
        rd(`ISME_STAT_OFS);
        chk({rv[0], 31'(n_sp)}, 32'h1);
        chk(32'(nbits), 32'h4);
        // Engine off, software drives the clock line
        n_st = 0;
        wr(`ISME_CTRL_OFS, 32'h400);
        wr(`ISME_CMD_OFS, 32'h1);
        rd(`ISME_STAT_OFS);
        chk({rv[4:3], scl_oe, sda_oe, 28'(n_st)}, 32'hA0000000);
        wr(`ISME_CTRL_OFS, 32'hC00);
        rd(`ISME_STAT_OFS);
        chk({rv[4:3], scl_oe, sda_oe, 28'(n_st)}, 32'h30000000);
        conclude();
    end
endmodule // tb_top
`default_nettype wire
